// File: srd_datagram_slave.sv
// srd_datagram_slave.sv: datagram slave core on the system clock, holding the shifter
// assumes: register file answers regRdData in the cycle regRdStb is high;
// assumes: the next frame starts at least four system clocks after chip select rises
`default_nettype none

module srd_datagram_slave (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        clkEn,
  input  wire logic        sck,
  input  wire logic        chipSelectLineN,
  input  wire logic        sdi,
  output logic             sdo,
  output logic             sdoOe,
  output logic [6:0]       regAddr,
  output logic [31:0]      regWrData,
  output logic             regWrStb,
  output logic             regRdStb,
  input  wire logic [31:0] regRdData,
  input  wire logic [31:0] driveState,
  input  wire logic [1:0]  globalFlags
);

  srd_link_if link ();

  srd_shifter uShifter (
    .sck             (sck),
    .chipSelectLineN (chipSelectLineN),
    .sdi             (sdi),
    .link            (link)
  );

  logic                                      csnMetaQ;
  logic                                      csnSyncQ;
  logic                                      csnPrevQ;
  logic                                      csnRise;
  logic [srd_pkg::FRAME_BITS_INT-1:0]        cmdWord;
  logic                                      cmdFull;
  logic                                      accessDirectionBit;
  logic                                      cmdAccept;
  logic [srd_pkg::ADDR_BITS-1:0]             cmdAddr;
  logic [srd_pkg::DATA_BITS-1:0]             cmdData;
  logic [srd_pkg::STATUS_BITS-1:0]           statusNow;
  srd_pkg::srd_state_e                       stateQ;
  logic [srd_pkg::ADDR_BITS-1:0]             regAddrQ;
  logic [srd_pkg::DATA_BITS-1:0]             regWrDataQ;
  logic                                      regWrStbQ;
  logic                                      regRdStbQ;
  logic [srd_pkg::DATA_BITS-1:0]             replyDataQ;
  logic [srd_pkg::STATUS_BITS-1:0]           statusQ;

  // chip select arrives from a pin: two flops, then an edge register
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      csnMetaQ <= srd_pkg::CSN_IDLE;
      csnSyncQ <= srd_pkg::CSN_IDLE;
      csnPrevQ <= srd_pkg::CSN_IDLE;
    end
    else if (clkEn)
    begin
      csnMetaQ <= chipSelectLineN;
      csnSyncQ <= csnMetaQ;
      csnPrevQ <= csnSyncQ;
    end
  end

  assign csnRise = csnSyncQ & ~csnPrevQ;

  // the shift word is quiet once chip select is high: the bus clock idles,
  // so it is read here without a word synchroniser
  assign cmdWord            = link.shiftWord;
  assign cmdFull            = link.frameFull;
  assign accessDirectionBit = cmdWord[srd_pkg::DIR_POS];
  assign cmdAddr            = cmdWord[srd_pkg::ADDR_MSB:srd_pkg::ADDR_LSB];
  assign cmdData            = cmdWord[srd_pkg::DATA_MSB:0];
  assign cmdAccept          = csnRise & cmdFull;

  // unused bits forced low so a careless master still reads a stable zero
  assign statusNow = {srd_pkg::STATUS_UNUSED,
                      driveState[srd_pkg::DRV_STANDSTILL_BIT],
                      driveState[srd_pkg::DRV_STALL_BIT],
                      globalFlags[srd_pkg::GF_FAULT_BIT],
                      globalFlags[srd_pkg::GF_RESTART_BIT]};

  // sequencing of one access: a read waits one cycle for the register file
  always_ff @(posedge clk)
  begin
    if (srst)
      stateQ <= srd_pkg::SRD_IDLE;
    else if (clkEn)
    begin
      case (stateQ)
        srd_pkg::SRD_IDLE:
          if (cmdAccept && !accessDirectionBit)
            stateQ <= srd_pkg::SRD_READ;
        srd_pkg::SRD_READ:
          stateQ <= srd_pkg::SRD_IDLE;
        default:
          stateQ <= srd_pkg::SRD_IDLE;
      endcase
    end
  end

  // address and write data towards the register file
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      regAddrQ   <= srd_pkg::ADDR_RESET;
      regWrDataQ <= srd_pkg::DATA_RESET;
    end
    else if (clkEn && cmdAccept)
    begin
      regAddrQ <= cmdAddr;
      if (accessDirectionBit)
        regWrDataQ <= cmdData;
    end
  end

  // one-cycle strobes; a short frame raises neither
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      regWrStbQ <= 1'h0;
      regRdStbQ <= 1'h0;
    end
    else if (clkEn)
    begin
      regWrStbQ <= cmdAccept & accessDirectionBit;
      regRdStbQ <= cmdAccept & ~accessDirectionBit;
    end
  end

  // reply word for the next frame; status is caught as each access ends
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      replyDataQ <= srd_pkg::DATA_RESET;
      statusQ    <= srd_pkg::STATUS_RESET;
    end
    else if (clkEn)
    begin
      if (stateQ == srd_pkg::SRD_READ)
      begin
        replyDataQ <= regRdData;
        statusQ    <= statusNow;
      end
      else if (cmdAccept && accessDirectionBit)
      begin
        replyDataQ <= cmdData;
        statusQ    <= statusNow;
      end
    end
  end

  // only changes while deselected, so the shifter sees a steady word
  assign link.replyWord = {statusQ, replyDataQ};

  assign sdo       = link.sdoBit;
  assign sdoOe     = link.sdoEn;
  assign regAddr   = regAddrQ;
  assign regWrData = regWrDataQ;
  assign regWrStb  = regWrStbQ;
  assign regRdStb  = regRdStbQ;

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (srst || !clkEn);

  sequence wrTakenS;
    cmdAccept && accessDirectionBit;
  endsequence

  sequence rdTakenS;
    cmdAccept && !accessDirectionBit;
  endsequence

  sequence rdFinishS;
    (regRdStbQ && stateQ == srd_pkg::SRD_READ) ##1 (stateQ == srd_pkg::SRD_IDLE);
  endsequence

  property wrStrobeP;
    wrTakenS |=> (regWrStbQ && !regRdStbQ && regWrDataQ == $past(cmdData)
                  && regAddrQ == $past(cmdAddr));
  endproperty

  property rdPipeP;
    rdTakenS |=> rdFinishS;
  endproperty

  property rdReturnP;
    (stateQ == srd_pkg::SRD_READ) |=> (replyDataQ == $past(regRdData));
  endproperty

  property wrEchoP;
    wrTakenS |=> (replyDataQ == $past(cmdData)) ##1 $stable(replyDataQ);
  endproperty

  property shortIgnoreP;
    (csnRise && !cmdFull) |=> (!regWrStbQ && !regRdStbQ && $stable(replyDataQ)
                               && $stable(statusQ) && $stable(regWrDataQ));
  endproperty

  property statusCatchP;
    (wrTakenS or (stateQ == srd_pkg::SRD_READ)) |=>
      (statusQ[srd_pkg::ST_STANDSTILL_POS] == $past(driveState[srd_pkg::DRV_STANDSTILL_BIT])
       && statusQ[srd_pkg::ST_STALL_POS] == $past(driveState[srd_pkg::DRV_STALL_BIT]));
  endproperty

  wr_strobe_a: assert property (wrStrobeP)
    else $error("write frame did not strobe its address and data");

  rd_pipeline_a: assert property (rdPipeP)
    else $error("read frame did not run strobe then return");

  rd_return_a: assert property (rdReturnP)
    else $error("read data not placed in the reply word");

  wr_echo_a: assert property (wrEchoP)
    else $error("reply does not echo the previous write data");

  read_no_store_a: assert property (rdTakenS |=> !regWrStbQ ##1 !regWrStbQ)
    else $error("read frame caused a register write");

  short_frame_a: assert property (shortIgnoreP)
    else $error("short frame changed state");

  status_drive_a: assert property (statusCatchP)
    else $error("drive state flags not caught into the status byte");

  status_flags_a: assert property (
    (wrTakenS or (stateQ == srd_pkg::SRD_READ)) |=>
      (statusQ[srd_pkg::ST_FAULT_POS:srd_pkg::ST_RESTART_POS] == $past(globalFlags)))
    else $error("global flags not caught into the status byte");

  status_unused_a: assert property (
    link.replyWord[srd_pkg::FRAME_BITS_INT-1:srd_pkg::FRAME_BITS_INT-4]
      == srd_pkg::STATUS_UNUSED)
    else $error("unused status bits not zero");

  strobe_pulse_a: assert property (
    (regWrStbQ || regRdStbQ) |=> !(regWrStbQ || regRdStbQ))
    else $error("access strobe longer than one cycle");

  // between accesses the register-side view must not drift
  sequence noAccessS;
    !cmdAccept && stateQ == srd_pkg::SRD_IDLE;
  endsequence

  property addrHoldP;
    noAccessS |=> $stable(regAddrQ);
  endproperty

  property replyHoldP;
    noAccessS |=> ($stable(replyDataQ) && $stable(statusQ));
  endproperty

  addr_hold_a: assert property (addrHoldP)
    else $error("register address moved without an accepted frame");

  reply_hold_a: assert property (replyHoldP)
    else $error("reply word moved without an accepted frame");

  wr_data_hold_a: assert property (
    !(cmdAccept && accessDirectionBit) |=> $stable(regWrDataQ))
    else $error("write data moved without an accepted write frame");

  accept_strobe_a: assert property (cmdAccept |=> (regWrStbQ ^ regRdStbQ))
    else $error("accepted frame did not raise exactly one strobe");

endmodule : srd_datagram_slave

`default_nettype wire

// File: srd_pkg.sv
// srd_pkg.sv: constants and types shared by the datagram slave and its link shifter
// assumes: compiled before every other file of the block
`default_nettype none

package srd_pkg;

  // datagram geometry
  localparam int         FRAME_BITS_INT = 40;
  localparam logic [5:0] FRAME_BITS     = 6'h28;
  localparam logic [5:0] LAST_BIT_CNT   = 6'h27;
  localparam logic [5:0] CNT_ZERO       = 6'h00;
  localparam logic [5:0] CNT_ONE        = 6'h01;
  localparam int         DATA_BITS      = 32;
  localparam int         ADDR_BITS      = 7;
  localparam int         STATUS_BITS    = 8;
  localparam int         DIR_POS        = 39;
  localparam int         ADDR_MSB       = 38;
  localparam int         ADDR_LSB       = 32;
  localparam int         DATA_MSB       = 31;

  // reply status byte layout
  localparam int         ST_STANDSTILL_POS = 3;
  localparam int         ST_STALL_POS      = 2;
  localparam int         ST_FAULT_POS      = 1;
  localparam int         ST_RESTART_POS    = 0;
  localparam int         ST_UNUSED_MSB     = 7;
  localparam int         ST_UNUSED_LSB     = 4;
  localparam logic [3:0] STATUS_UNUSED     = 4'h0;

  // source bits in the drive state and global flag registers
  localparam int DRV_STANDSTILL_BIT = 31;
  localparam int DRV_STALL_BIT      = 24;
  localparam int GF_FAULT_BIT       = 1;
  localparam int GF_RESTART_BIT     = 0;

  // reset values
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [31:0] DATA_RESET   = 32'h0000_0000;
  localparam logic [6:0]  ADDR_RESET   = 7'h00;
  localparam logic        CSN_IDLE     = 1'h1;

  typedef enum logic {SRD_IDLE, SRD_READ} srd_state_e;

endpackage : srd_pkg

`default_nettype wire

// File: srd_link_if.sv
// srd_link_if.sv: signals between the system-clock core and the bus-clock shifter
// assumes: replyWord only changes while chip select is high
`default_nettype none

interface srd_link_if;
  logic [srd_pkg::FRAME_BITS_INT-1:0] replyWord;
  logic [srd_pkg::FRAME_BITS_INT-1:0] shiftWord;
  logic                               frameFull;
  logic                               sdoBit;
  logic                               sdoEn;

  modport core (
    output replyWord,
    input  shiftWord,
    input  frameFull,
    input  sdoBit,
    input  sdoEn
  );

  modport shifter (
    input  replyWord,
    output shiftWord,
    output frameFull,
    output sdoBit,
    output sdoEn
  );
endinterface : srd_link_if

`default_nettype wire

// File: srd_shifter.sv
// srd_shifter.sv: bus-clock shift register of the datagram slave
// assumes: bus clock idles high, chip select meets its setup to the bus clock
`default_nettype none

module srd_shifter (
  input  wire logic sck,
  input  wire logic chipSelectLineN,
  input  wire logic sdi,
  srd_link_if.shifter link
);

  logic [5:0]                          bitCntQ;
  logic [srd_pkg::FRAME_BITS_INT-1:0]  shiftQ;
  logic                                fullQ;
  logic                                sdoQ;
  logic                                sdoEnQ;

  // count saturates, so long frames keep shifting with the same path
  always_ff @(posedge sck or posedge chipSelectLineN)
  begin
    if (chipSelectLineN)
      bitCntQ <= srd_pkg::CNT_ZERO;
    else if (bitCntQ != srd_pkg::FRAME_BITS)
      bitCntQ <= bitCntQ + srd_pkg::CNT_ONE;
  end

  // first edge of a frame loads the reply and takes bit one in the same step
  always_ff @(posedge sck)
  begin
    if (!chipSelectLineN)
    begin
      if (bitCntQ == srd_pkg::CNT_ZERO)
        shiftQ <= {link.replyWord[srd_pkg::FRAME_BITS_INT-2:0], sdi};
      else
        shiftQ <= {shiftQ[srd_pkg::FRAME_BITS_INT-2:0], sdi};
    end
  end

  // held after chip select rises: the core reads it as a quiet word
  always_ff @(posedge sck)
  begin
    if (!chipSelectLineN)
      fullQ <= (bitCntQ >= srd_pkg::LAST_BIT_CNT);
  end

  // output moves after the falling edge; after forty bits the received
  // stream itself comes out, which is what a daisy chain needs
  always_ff @(negedge sck or posedge chipSelectLineN)
  begin
    if (chipSelectLineN)
    begin
      sdoQ   <= 1'h0;
      sdoEnQ <= 1'h0;
    end
    else
    begin
      sdoEnQ <= 1'h1;
      if (bitCntQ == srd_pkg::CNT_ZERO)
        sdoQ <= link.replyWord[srd_pkg::DIR_POS];
      else
        sdoQ <= shiftQ[srd_pkg::FRAME_BITS_INT-1];
    end
  end

  assign link.shiftWord = shiftQ;
  assign link.frameFull = fullQ;
  assign link.sdoBit    = sdoQ;
  assign link.sdoEn     = sdoEnQ;

  property shiftInP;
    @(posedge sck) disable iff (chipSelectLineN)
      (bitCntQ != srd_pkg::CNT_ZERO) |=> (shiftQ[0] == $past(sdi));
  endproperty

  shift_in_a: assert property (shiftInP)
    else $error("serial input bit not shifted into lsb");

  full_after_a: assert property (
    @(posedge sck) disable iff (chipSelectLineN)
      (bitCntQ == srd_pkg::LAST_BIT_CNT) |=> fullQ)
    else $error("frame not marked full after fortieth bit");

endmodule : srd_shifter

`default_nettype wire

// File: srd_host_model.sv
// srd_host_model.sv: behavioural spi master (mode 3) that drives the datagram slave
// assumes: sdo is the resolved line, high impedance while the slave is deselected
`default_nettype none

module srd_host_model (
  output logic      sck,
  output logic      chipSelectLineN,
  output logic      sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sck = 1'b1;
    chipSelectLineN = 1'b1;
    sdi = 1'b0;
  end

  // bit clock only runs inside a frame; fewer than 40 bits only when a short frame is wanted
  // the whole reply goes back to the caller, status bits 7:4 are not interpreted here
  task automatic frame(input logic [79:0] tx, input int nBits, output logic [79:0] rx);
    rx = '0;
    #1.3;
    chipSelectLineN = 1'b0;
    #15;
    for (int i = nBits - 1; i >= 0; i--)
    begin
      sck = 1'b0;
      sdi = tx[i];
      #15;
      sck = 1'b1;
      rx[i] = sdo;
      #15;
    end
    chipSelectLineN = 1'b1;
    // released line must not look like a held bit
    sdi = ~sdi;
    #100;
  endtask : frame
endmodule : srd_host_model

`default_nettype wire

// File: tb.sv
// tb.sv: self-checking bench for the datagram slave driven by a behavioural spi master
// assumes: package, link interface, shifter, slave and host model are compiled first
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        srst;
  logic        clkEn;
  logic        sck;
  logic        chipSelectLineN;
  logic        sdi;
  logic        sdo;
  logic        sdoOe;
  logic [6:0]  regAddr;
  logic [31:0] regWrData;
  logic        regWrStb;
  logic        regRdStb;
  logic [31:0] regRdData;
  logic [31:0] driveState;
  logic [1:0]  globalFlags;
  wire         sdoLine = sdoOe ? sdo : 1'bz;
  int          err_count;
  int          comparisons;
  int          wrCnt;
  int          rdCnt;
  int          expWr;
  int          expRd;
  int          cycles;
  logic [7:0]  expSt;
  logic [31:0] expData;
  logic [31:0] lastWr;
  logic [6:0]  curAddr;
  logic [79:0] rx;
  logic [79:0] rxReply;
  // {dir+addr, data sent, register read data, status flags}
  logic [75:0] tbl [6] = '{76'h12_00000000_12345678_8, 76'h34_ffffffff_87654321_4,
                           76'h90_00011f10_deadbeef_2, 76'hff_80000001_0badf00d_1,
                           76'h00_00000000_c0de0001_f, 76'hc1_00021807_00000000_0};

  srd_datagram_slave u_srd_datagram_slave (
    .clk(clk), .srst(srst), .clkEn(clkEn), .sck(sck), .chipSelectLineN(chipSelectLineN),
    .sdi(sdi), .sdo(sdo), .sdoOe(sdoOe), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .driveState(driveState), .globalFlags(globalFlags)
  );

  srd_host_model u_srd_host_model (
    .sck(sck), .chipSelectLineN(chipSelectLineN), .sdi(sdi), .sdo(sdoLine)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  // strobe counting catches a pulse that stands longer than one cycle
  always @(posedge clk)
  begin
    cycles++;
    if (regWrStb === 1'b1)
      wrCnt++;
    if (regRdStb === 1'b1)
    begin
      rdCnt++;
      check(regAddr, curAddr);
    end
    if (cycles > 20000)
    begin
      err_count++;
      summarize();
    end
  end

  // extra leading junk bits 8'ha5 must come back out after the reply
  task automatic xact(input logic wr, input logic [6:0] a, input logic [31:0] d,
                      input logic [31:0] rd, input logic [3:0] st, input int extra);
    @(posedge clk);
    regRdData <= rd;
    driveState <= {st[3], 6'h15, st[2], 24'h5a5a5a};
    globalFlags <= st[1:0];
    curAddr = a;
    u_srd_host_model.frame({32'h0, 8'ha5, wr, a, d}, 40 + extra, rx);
    rxReply = rx >> extra;
    check(rxReply[39:32], expSt);
    check(rxReply[31:0], expData);
    if (extra > 0)
      check(rx & 80'hff, 80'ha5);
    if (wr)
    begin
      expWr++;
      lastWr = d;
    end
    else
      expRd++;
    check(wrCnt, expWr);
    check(rdCnt, expRd);
    check(regAddr, a);
    check(regWrData, lastWr);
    check(sdoOe, 1'b0);
    expSt = {4'h0, st};
    expData = wr ? d : rd;
  endtask : xact

  initial
  begin
    srst = 1'b1;
    clkEn = 1'b1;
    regRdData = '0;
    driveState = '0;
    globalFlags = '0;
    err_count = 0;
    comparisons = 0;
    wrCnt = 0;
    rdCnt = 0;
    expWr = 0;
    expRd = 0;
    cycles = 0;
    expSt = '0;
    expData = '0;
    lastWr = '0;
    curAddr = '0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    check(regAddr, 7'h00);
    check(regWrData, 32'h0);
    for (int i = 0; i < 6; i++)
      xact(tbl[i][75], tbl[i][74:68], tbl[i][67:36], tbl[i][35:4], tbl[i][3:0], 0);
    // short write frame with changed flags: must leave no trace
    @(posedge clk);
    globalFlags <= 2'h3;
    u_srd_host_model.frame(80'hd5fff, 20, rx);
    xact(1'b1, 7'h22, 32'h5555aaaa, 32'h0, 4'h5, 8);
    xact(1'b0, 7'h22, 32'h0, 32'h13579bdf, 4'h3, 0);
    // second reset in mid-run clears the pipelined reply
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    expSt = '0;
    expData = '0;
    lastWr = '0;
    check(regAddr, 7'h00);
    check(regWrData, 32'h0);
    xact(1'b0, 7'h05, 32'h0, 32'h2468ace0, 4'ha, 0);
    xact(1'b1, 7'h06, 32'h11, 32'h0, 4'h0, 0);
    summarize();
  end
endmodule : tb

`default_nettype wire
